// [rtl/packet_mmu_control.sv]
`timescale 1ns/1ps
// Contract
// - accept bit keeps crc-failed frames
// - otherwise drop silently, free pages
// - auto release frees sent pages, no completion
// - auto release: irq on run end or fatal
// - fatal: transmitter off, number queued, pages kept
// - link change feeds merged irq, enable clear acks
// - rollover feeds merged irq, counter read acks
// - transmit fault feeds irq, acked by enable writes
// - three irq enables reset to zero
// - select bit picks eeprom register set
// - reload starts read, self clears
// - store starts write, self clears
// - busy transfer reads reload and store high
// - transfer blocks all but status polling
// - reload finishes within 750 us
// - decode eight opcodes, busy at bit zero
// - reset op frees all, clears queues
// - remove pops receive queue head
// - remove-release pops and frees, busy meanwhile
// - release specific frees selected packet
// - enqueue pushes selected packet for sending
// - tx reset empties both queues, keeps pages
// - busy and failed set at write end
// - allocate updates result register
module packet_mmu_control #(
  parameter int EE_LIMIT = mmu_ctrl_pkg::EE_LIMIT_CYC
) (
  input  wire logic                            core_clk,
  input  wire logic                            arst_n,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [7:0]                      paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire mmu_ctrl_pkg::rx_event_s         rxEvent,
  input  wire mmu_ctrl_pkg::tx_event_s         txEvent,
  input  wire logic                            txTake,
  input  wire logic                            linkUpPin,
  input  wire logic                            counterRollover,
  input  wire logic [15:0]                     statCounter,
  input  wire logic                            eeDone,
  output logic      [mmu_ctrl_pkg::PKT_W-1:0]  rxHead,
  output logic                                 rxPending,
  output logic      [mmu_ctrl_pkg::PKT_W-1:0]  txHead,
  output logic                                 txPending,
  output logic      [mmu_ctrl_pkg::PKT_W-1:0]  complHead,
  output logic                                 complPending,
  output logic                                 txEmptyEvent,
  output logic                                 mergedEventIrq,
  output logic                                 transmitterOn,
  output logic                                 eeRequest,
  output logic                                 eeStoreDir,
  output logic                                 eeSelGpr
);
  localparam int PW = mmu_ctrl_pkg::PKT_W;
  localparam int NP = mmu_ctrl_pkg::NUM_PKTS;

  // apb decode; the slave never inserts wait states
  logic access;
  logic setupRd;
  logic wrEn;
  logic rdEn;
  logic hit;
  logic eeActive_reg;
  assign pready  = 1'b1;
  assign access  = psel & penable;
  always_comb begin
    case (paddr)
      mmu_ctrl_pkg::ADDR_ADAPTER_CONTROL,
      mmu_ctrl_pkg::ADDR_MMU_COMMAND,
      mmu_ctrl_pkg::ADDR_PACKET_SELECT,
      mmu_ctrl_pkg::ADDR_ALLOC_RESULT,
      mmu_ctrl_pkg::ADDR_FIFO_PORTS,
      mmu_ctrl_pkg::ADDR_TX_CONFIG,
      mmu_ctrl_pkg::ADDR_EVENT_STATUS,
      mmu_ctrl_pkg::ADDR_STAT_COUNTER: hit = 1'b1;
      default:                         hit = 1'b0;
    endcase
  end
  assign pslverr = access & ~hit;
  assign setupRd = psel & ~penable & ~pwrite;
  // transfers other than the status poll are dropped while busy
  assign wrEn = access & pwrite & ~eeActive_reg;
  assign rdEn = access & ~pwrite & ~eeActive_reg;

  // adapter_control storage
  logic acceptCrc_reg;
  logic autoRelease_reg;
  logic linkEn_reg;
  logic rollEn_reg;
  logic txfEn_reg;
  logic eeSel_reg;
  logic eeStore_reg;
  logic ctlWr;
  logic [15:0] ctlWdata;
  assign ctlWr    = wrEn && paddr == mmu_ctrl_pkg::ADDR_ADAPTER_CONTROL;
  assign ctlWdata = pwdata[15:0];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acceptCrc_reg   <= 1'b0;
      autoRelease_reg <= 1'b0;
      linkEn_reg      <= 1'b0;
      rollEn_reg      <= 1'b0;
      txfEn_reg       <= 1'b0;
      eeSel_reg       <= 1'b0;
    end else if (ctlWr) begin
      acceptCrc_reg   <= ctlWdata[mmu_ctrl_pkg::CTL_ACCEPT_CRC];
      autoRelease_reg <= ctlWdata[mmu_ctrl_pkg::CTL_AUTO_REL];
      linkEn_reg      <= ctlWdata[mmu_ctrl_pkg::CTL_LINK_EN];
      rollEn_reg      <= ctlWdata[mmu_ctrl_pkg::CTL_ROLL_EN];
      txfEn_reg       <= ctlWdata[mmu_ctrl_pkg::CTL_TXF_EN];
      eeSel_reg       <= ctlWdata[mmu_ctrl_pkg::CTL_EE_SEL];
    end
  end

  // eeprom sequencing; a reload runs straight out of reset
  logic [31:0] eeTimer_reg;
  logic        eeEnd;
  assign eeEnd = eeDone || eeTimer_reg == 32'(EE_LIMIT - 2);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      eeActive_reg <= 1'b1;
      eeStore_reg  <= 1'b0;
      eeTimer_reg  <= '0;
    end else if (eeActive_reg) begin
      eeTimer_reg <= eeTimer_reg + 32'h1;
      if (eeEnd) begin
        eeActive_reg <= 1'b0;
        eeTimer_reg  <= '0;
      end
    end else if (ctlWr && (ctlWdata[mmu_ctrl_pkg::CTL_RELOAD] ||
                           ctlWdata[mmu_ctrl_pkg::CTL_STORE])) begin
      eeActive_reg <= 1'b1;
      // store wins only when reload is not also asked for
      eeStore_reg  <= ~ctlWdata[mmu_ctrl_pkg::CTL_RELOAD];
    end
  end
  assign eeRequest  = eeActive_reg;
  assign eeStoreDir = eeStore_reg;
  assign eeSelGpr   = eeSel_reg;

  // link pin synchroniser and change detect
  logic linkMeta_reg;
  logic linkSync_reg;
  logic linkLast_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      linkMeta_reg <= 1'b0;
      linkSync_reg <= 1'b0;
      linkLast_reg <= 1'b0;
    end else begin
      linkMeta_reg <= linkUpPin;
      linkSync_reg <= linkMeta_reg;
      linkLast_reg <= linkSync_reg;
    end
  end

  // transmitter enable and last transmit status
  logic txOn_reg;
  logic txSuccess_reg;
  logic txOnWr;
  logic txFatal;
  assign txOnWr  = wrEn && paddr == mmu_ctrl_pkg::ADDR_TX_CONFIG;
  assign txFatal = txEvent.done & ~txEvent.ok;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txOn_reg      <= 1'b0;
      txSuccess_reg <= 1'b0;
    end else begin
      if (txFatal) begin
        txOn_reg <= 1'b0;
      end else if (txOnWr) begin
        txOn_reg <= pwdata[0];
      end
      if (txEvent.done) begin
        txSuccess_reg <= txEvent.ok;
      end
    end
  end
  assign transmitterOn = txOn_reg;

  // sticky event causes; a new event beats its own acknowledge
  logic linkChg_reg;
  logic roll_reg;
  logic txFault_reg;
  logic ackLink;
  logic ackRoll;
  logic ackFault;
  assign ackLink  = ctlWr & linkEn_reg &
                    ~ctlWdata[mmu_ctrl_pkg::CTL_LINK_EN];
  assign ackRoll  = rdEn && paddr == mmu_ctrl_pkg::ADDR_STAT_COUNTER;
  assign ackFault = (txOnWr & pwdata[0]) |
                    (ctlWr & ~ctlWdata[mmu_ctrl_pkg::CTL_TXF_EN]);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      linkChg_reg <= 1'b0;
      roll_reg    <= 1'b0;
      txFault_reg <= 1'b0;
    end else begin
      if (linkSync_reg != linkLast_reg) begin
        linkChg_reg <= 1'b1;
      end else if (ackLink) begin
        linkChg_reg <= 1'b0;
      end
      if (counterRollover) begin
        roll_reg <= 1'b1;
      end else if (ackRoll) begin
        roll_reg <= 1'b0;
      end
      if (txFatal && txOn_reg) begin
        txFault_reg <= 1'b1;
      end else if (ackFault) begin
        txFault_reg <= 1'b0;
      end
    end
  end
  assign mergedEventIrq = (linkChg_reg & linkEn_reg) |
                          (roll_reg & rollEn_reg) |
                          (txFault_reg & txfEn_reg);

  // command decode, only the opcode field is looked at
  logic          cmdWr;
  logic [2:0]    op;
  logic          mmuReset;
  logic          txQReset;
  logic [PW-1:0] pktSel_reg;
  assign cmdWr    = wrEn && paddr == mmu_ctrl_pkg::ADDR_MMU_COMMAND;
  assign op       = pwdata[mmu_ctrl_pkg::CMD_OP_LSB +: 3];
  assign mmuReset = cmdWr && op == mmu_ctrl_pkg::OP_RESET;
  assign txQReset = mmuReset ||
                    (cmdWr && op == mmu_ctrl_pkg::OP_TX_RST);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pktSel_reg <= '0;
    end else if (mmuReset) begin
      pktSel_reg <= '0;
    end else if (wrEn && paddr == mmu_ctrl_pkg::ADDR_PACKET_SELECT) begin
      pktSel_reg <= pwdata[PW-1:0];
    end
  end

  // release engine; busy covers the page free cycle
  mmu_ctrl_pkg::mmu_state_e state_reg;
  logic [PW-1:0]            relPkt_reg;
  logic                     busy;
  assign busy = (state_reg == mmu_ctrl_pkg::MMU_RELEASE);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg  <= mmu_ctrl_pkg::MMU_IDLE;
      relPkt_reg <= '0;
    end else begin
      case (state_reg)
        mmu_ctrl_pkg::MMU_IDLE: begin
          if (cmdWr && op == mmu_ctrl_pkg::OP_REM_REL && rxPending) begin
            state_reg  <= mmu_ctrl_pkg::MMU_RELEASE;
            relPkt_reg <= rxHead;
          end else if (cmdWr && op == mmu_ctrl_pkg::OP_RELEASE) begin
            state_reg  <= mmu_ctrl_pkg::MMU_RELEASE;
            relPkt_reg <= pktSel_reg;
          end
        end
        mmu_ctrl_pkg::MMU_RELEASE: state_reg <= mmu_ctrl_pkg::MMU_IDLE;
        default:                   state_reg <= mmu_ctrl_pkg::MMU_IDLE;
      endcase
    end
  end

  // page ownership map and frees from every source
  logic [NP-1:0] allocMap_reg;
  logic [NP-1:0] freeMask;
  logic [NP-1:0] setMask;
  logic          rxDrop;
  logic          txAutoFree;
  logic          freeAny;
  logic [4:0]    freeIdx;
  logic          allocPend_reg;
  logic          allocFailed_reg;
  logic [PW-1:0] allocPkt_reg;
  assign rxDrop     = rxEvent.done & rxEvent.crcBad & ~acceptCrc_reg;
  assign txAutoFree = txEvent.done & txEvent.ok & autoRelease_reg;

  always_comb begin
    freeAny = 1'b0;
    freeIdx = '0;
    for (int i = NP - 1; i >= 0; i--) begin
      if (!allocMap_reg[i]) begin
        freeAny = 1'b1;
        freeIdx = 5'(i);
      end
    end
  end

  always_comb begin
    freeMask = '0;
    setMask  = '0;
    if (busy) begin
      freeMask[relPkt_reg[4:0]] = 1'b1;
    end
    if (rxDrop) begin
      freeMask[rxEvent.pkt[4:0]] = 1'b1;
    end
    if (txAutoFree) begin
      freeMask[txEvent.pkt[4:0]] = 1'b1;
    end
    if (allocPend_reg && freeAny) begin
      setMask[freeIdx] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      allocMap_reg <= '0;
    end else if (mmuReset) begin
      allocMap_reg <= '0;
    end else begin
      allocMap_reg <= (allocMap_reg & ~freeMask) | setMask;
    end
  end

  // allocation result; failed rises at the write, clears when served
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      allocPend_reg   <= 1'b0;
      allocFailed_reg <= 1'b1;
      allocPkt_reg    <= '0;
    end else if (mmuReset) begin
      allocPend_reg   <= 1'b0;
      allocFailed_reg <= 1'b1;
    end else if (cmdWr && op == mmu_ctrl_pkg::OP_ALLOC) begin
      allocPend_reg   <= 1'b1;
      allocFailed_reg <= 1'b1;
    end else if (allocPend_reg && freeAny) begin
      allocPend_reg   <= 1'b0;
      allocFailed_reg <= 1'b0;
      allocPkt_reg    <= {1'b0, freeIdx};
    end
  end

  // receive, transmit and completion queues
  logic rxPush;
  logic rxPop;
  logic rxEmpty;
  logic txEmpty;
  logic cpEmpty;
  logic cpPush;
  logic [PW-1:0] cpData;
  assign rxPush = rxEvent.done & ~rxDrop;
  assign rxPop  = cmdWr && (op == mmu_ctrl_pkg::OP_REMOVE ||
                            op == mmu_ctrl_pkg::OP_REM_REL);
  // a fatal packet is always reported, even under auto release
  assign cpPush = txEvent.done & ~txAutoFree;
  assign cpData = txEvent.pkt;

  pkt_queue rxQueue (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clear    (mmuReset),
    .push     (rxPush),
    .pushData (rxEvent.pkt),
    .pop      (rxPop),
    .headData (rxHead),
    .empty    (rxEmpty),
    .full     ()
  );

  pkt_queue txQueue (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clear    (txQReset),
    .push     (cmdWr && op == mmu_ctrl_pkg::OP_ENQUEUE),
    .pushData (pktSel_reg),
    .pop      (txTake),
    .headData (txHead),
    .empty    (txEmpty),
    .full     ()
  );

  pkt_queue complQueue (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clear    (txQReset),
    .push     (cpPush),
    .pushData (cpData),
    .pop      (wrEn && paddr == mmu_ctrl_pkg::ADDR_FIFO_PORTS),
    .headData (complHead),
    .empty    (cpEmpty),
    .full     ()
  );

  assign rxPending    = ~rxEmpty;
  assign txPending    = ~txEmpty & txOn_reg;
  assign complPending = ~cpEmpty;

  // end of a queued run, one pulse
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txEmptyEvent <= 1'b0;
    end else begin
      txEmptyEvent <= txEvent.done & txEvent.ok & txEmpty;
    end
  end

  // read data is captured in the setup cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= '0;
    end else if (setupRd) begin
      prdata <= '0;
      if (eeActive_reg) begin
        if (paddr == mmu_ctrl_pkg::ADDR_ADAPTER_CONTROL) begin
          prdata[1:0] <= 2'h3;
        end
      end else begin
        case (paddr)
          mmu_ctrl_pkg::ADDR_ADAPTER_CONTROL: begin
            prdata[15:0] <= mmu_ctrl_pkg::CTL_RSVD_ONES;
            prdata[mmu_ctrl_pkg::CTL_ACCEPT_CRC] <= acceptCrc_reg;
            prdata[mmu_ctrl_pkg::CTL_AUTO_REL]   <= autoRelease_reg;
            prdata[mmu_ctrl_pkg::CTL_LINK_EN]    <= linkEn_reg;
            prdata[mmu_ctrl_pkg::CTL_ROLL_EN]    <= rollEn_reg;
            prdata[mmu_ctrl_pkg::CTL_TXF_EN]     <= txfEn_reg;
            prdata[mmu_ctrl_pkg::CTL_EE_SEL]     <= eeSel_reg;
          end
          mmu_ctrl_pkg::ADDR_MMU_COMMAND:
            prdata[mmu_ctrl_pkg::CMD_BUSY] <= busy;
          mmu_ctrl_pkg::ADDR_PACKET_SELECT:
            prdata[PW-1:0] <= pktSel_reg;
          mmu_ctrl_pkg::ADDR_ALLOC_RESULT: begin
            prdata[mmu_ctrl_pkg::ARR_FAILED] <= allocFailed_reg;
            prdata[PW-1:0] <= allocPkt_reg;
          end
          mmu_ctrl_pkg::ADDR_FIFO_PORTS: begin
            prdata[15]   <= rxEmpty;
            prdata[13:8] <= rxHead;
            prdata[7]    <= cpEmpty;
            prdata[5:0]  <= complHead;
          end
          mmu_ctrl_pkg::ADDR_TX_CONFIG:
            prdata[0] <= txOn_reg;
          mmu_ctrl_pkg::ADDR_EVENT_STATUS:
            prdata[5:0] <= {mergedEventIrq, txFault_reg, roll_reg,
                            linkChg_reg, linkSync_reg, txSuccess_reg};
          mmu_ctrl_pkg::ADDR_STAT_COUNTER:
            prdata[15:0] <= statCounter;
          default: prdata <= '0;
        endcase
      end
    end
  end
endmodule // packet_mmu_control

// [rtl/mmu_ctrl_pkg.sv]
package mmu_ctrl_pkg;
  // register byte addresses on the apb slave
  localparam logic [7:0] ADDR_ADAPTER_CONTROL = 8'h0c;
  localparam logic [7:0] ADDR_MMU_COMMAND     = 8'h10;
  localparam logic [7:0] ADDR_PACKET_SELECT   = 8'h14;
  localparam logic [7:0] ADDR_ALLOC_RESULT    = 8'h18;
  localparam logic [7:0] ADDR_FIFO_PORTS      = 8'h1c;
  localparam logic [7:0] ADDR_TX_CONFIG       = 8'h20;
  localparam logic [7:0] ADDR_EVENT_STATUS    = 8'h24;
  localparam logic [7:0] ADDR_STAT_COUNTER    = 8'h28;

  // adapter_control field positions
  localparam int CTL_ACCEPT_CRC = 14;
  localparam int CTL_AUTO_REL   = 11;
  localparam int CTL_LINK_EN    = 7;
  localparam int CTL_ROLL_EN    = 6;
  localparam int CTL_TXF_EN     = 5;
  localparam int CTL_EE_SEL     = 2;
  localparam int CTL_RELOAD     = 1;
  localparam int CTL_STORE      = 0;
  // reserved bits that read back as one
  localparam logic [15:0] CTL_RSVD_ONES = 16'h1210;

  // command and allocation result register fields
  localparam int CMD_OP_LSB = 5;
  localparam int CMD_BUSY   = 0;
  localparam int ARR_FAILED = 7;

  // operation codes
  localparam logic [2:0] OP_NOOP    = 3'h0;
  localparam logic [2:0] OP_ALLOC   = 3'h1;
  localparam logic [2:0] OP_RESET   = 3'h2;
  localparam logic [2:0] OP_REMOVE  = 3'h3;
  localparam logic [2:0] OP_REM_REL = 3'h4;
  localparam logic [2:0] OP_RELEASE = 3'h5;
  localparam logic [2:0] OP_ENQUEUE = 3'h6;
  localparam logic [2:0] OP_TX_RST  = 3'h7;

  // packet numbers and queue geometry
  localparam int PKT_W      = 6;
  localparam int NUM_PKTS   = 32;
  localparam int QUEUE_AW   = 5;
  localparam int QUEUE_D    = 32;

  // eeprom transfer worst case
  localparam int CLK_MHZ       = 125;
  localparam int EE_RELOAD_US  = 750;
  localparam int EE_LIMIT_CYC  = EE_RELOAD_US * CLK_MHZ;

  typedef enum {MMU_IDLE, MMU_RELEASE} mmu_state_e;

  // receive frame completion from the mac
  typedef struct packed {
    logic             done;
    logic             crcBad;
    logic [PKT_W-1:0] pkt;
  } rx_event_s;

  // transmit completion from the mac
  typedef struct packed {
    logic             done;
    logic             ok;
    logic [PKT_W-1:0] pkt;
  } tx_event_s;
endpackage

// [rtl/pkt_queue.sv]
`timescale 1ns/1ps
// packet-number queue, head word comes out of a register
module pkt_queue (
  input  wire logic                          core_clk,
  input  wire logic                          arst_n,
  input  wire logic                          clear,
  input  wire logic                          push,
  input  wire logic [mmu_ctrl_pkg::PKT_W-1:0] pushData,
  input  wire logic                          pop,
  output logic      [mmu_ctrl_pkg::PKT_W-1:0] headData,
  output logic                               empty,
  output logic                               full
);
  localparam int AW = mmu_ctrl_pkg::QUEUE_AW;
  logic [mmu_ctrl_pkg::PKT_W-1:0] mem [mmu_ctrl_pkg::QUEUE_D];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW-1:0] rdPtr_next;
  logic [AW:0]   count_reg;
  logic [AW:0]   count_next;
  logic          doPush;
  logic          doPop;

  assign doPush = push & ~full & ~clear;
  assign doPop  = pop & ~empty & ~clear;
  assign empty  = (count_reg == '0);
  assign full   = (count_reg == (AW+1)'(mmu_ctrl_pkg::QUEUE_D));

  // one write port, one entry per generate slot
  for (genvar g = 0; g < mmu_ctrl_pkg::QUEUE_D; g++) begin : gEntry
    always_ff @(posedge core_clk) begin
      if (doPush && wrPtr_reg == AW'(g)) begin
        mem[g] <= pushData;
      end
    end
  end

  always_comb begin
    rdPtr_next = doPop ? rdPtr_reg + 1'b1 : rdPtr_reg;
    count_next = count_reg;
    if (clear) begin
      count_next = '0;
    end else if (doPush && !doPop) begin
      count_next = count_reg + 1'b1;
    end else if (doPop && !doPush) begin
      count_next = count_reg - 1'b1;
    end
  end

  // pointers and fill level
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else if (clear) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      wrPtr_reg <= doPush ? wrPtr_reg + 1'b1 : wrPtr_reg;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
    end
  end

  // registered head; bypass when the new word lands in the head slot
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      headData <= '0;
    end else if (count_next == '0) begin
      headData <= '0;
    end else if (doPush && wrPtr_reg == rdPtr_next) begin
      headData <= pushData;
    end else begin
      headData <= mem[rdPtr_next];
    end
  end
endmodule // pkt_queue

// [bench/packet_mmu_control_checker.sv]
`timescale 1ns/1ps
// port-level relations of the packet memory control block
module packet_mmu_control_checker #(
  parameter int EE_LIMIT = mmu_ctrl_pkg::EE_LIMIT_CYC
) (
  input wire logic                    core_clk,
  input wire logic                    arst_n,
  input wire mmu_ctrl_pkg::rx_event_s rxEvent,
  input wire mmu_ctrl_pkg::tx_event_s txEvent,
  input wire logic                    eeDone,
  input wire logic                    rxPending,
  input wire logic                    txPending,
  input wire logic                    txEmptyEvent,
  input wire logic                    complPending,
  input wire logic                    mergedEventIrq,
  input wire logic                    transmitterOn,
  input wire logic                    eeRequest,
  input wire logic                    eeStoreDir
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  int eeCnt;
  // age of the running transfer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) eeCnt <= 0;
    else eeCnt <= eeRequest ? eeCnt + 1 : 0;
  end
  chk_ee_done: assert property (
    eeRequest && eeDone |=> !eeRequest) else $error("transfer kept running");
  chk_ee_bound: assert property (
    eeCnt < EE_LIMIT) else $error("transfer ran past its limit");
  chk_ee_dir: assert property (
    eeRequest [*2] |-> $stable(eeStoreDir)) else $error("direction moved");
  chk_fatal_off: assert property (
    txEvent.done && !txEvent.ok |=> !transmitterOn) else $error("tx stayed on");
  chk_fatal_queue: assert property (
    txEvent.done && !txEvent.ok |-> ##[1:2] complPending)
    else $error("failed packet not queued");
  chk_run_end: assert property (
    txEvent.done && txEvent.ok && transmitterOn && !txPending |=> txEmptyEvent)
    else $error("run end not flagged");
  chk_rx_keep: assert property (
    rxEvent.done && !rxEvent.crcBad |-> ##[1:2] rxPending)
    else $error("good frame not queued");
  chk_irq_quiet: assert property (
    $rose(arst_n) |-> !mergedEventIrq [*4]) else $error("irq after reset");
endmodule // packet_mmu_control_checker

bind packet_mmu_control packet_mmu_control_checker #(.EE_LIMIT(EE_LIMIT))
  packet_mmu_control_checker_i (.core_clk, .arst_n, .rxEvent, .txEvent,
  .eeDone, .rxPending, .txPending, .complPending, .mergedEventIrq,
  .transmitterOn, .eeRequest, .eeStoreDir, .txEmptyEvent);

// [bench/host_model.sv]
`timescale 1ns/1ps
// host cpu on the register bus, an apb master
module host_model (
  input  wire logic        core_clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic             hung
);
  initial {psel, penable, pwrite, paddr, pwdata, hung} = '0;
  // request held until pready is seen, then one settle edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    int n = 0;
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    if (n >= 50) hung <= 1'b1;
    {psel, penable} <= 2'b00;
    @(posedge core_clk);
    #1;
  endtask
  // normal accesses wait until reload and store both read zero
  task automatic poll();
    logic [31:0] r;
    int k = 0;
    do begin
      xfer(1'b0, mmu_ctrl_pkg::ADDR_ADAPTER_CONTROL, 32'h0, r);
      k++;
    end while (r[1:0] !== 2'b00 && k < 60);
    if (k >= 60) hung <= 1'b1;
  endtask
endmodule // host_model

// [bench/testbench.sv]
`timescale 1ns/1ps
// register rows, then queue, event and eeprom sequences
module testbench;
  logic        core_clk, arst_n, psel, penable, pwrite, pready, hung;
  logic        txTake, linkUpPin, counterRollover, eeDone, rxPending;
  logic        txPending, complPending, mergedEventIrq, transmitterOn;
  logic        eeRequest, eeStoreDir, eeSelGpr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  rxHead, txHead, complHead;
  logic [15:0] statCounter;
  mmu_ctrl_pkg::rx_event_s rxEvent;
  mmu_ctrl_pkg::tx_event_s txEvent;
  int failures = 0, nTests = 0;
  typedef struct {logic [7:0] a; logic [31:0] w, e;} row_s;
  // write, then read back; reserved ones and dead addresses included
  row_s rows[5] = '{'{8'h0c, 32'h48e4, 32'h5af4}, '{8'h0c, 32'h0, 32'h1210},
                    '{8'h14, 32'h2a, 32'h2a}, '{8'h10, 32'hff1f, 32'h0},
                    '{8'h3c, 32'hffff, 32'h0}};
  packet_mmu_control #(.EE_LIMIT(20)) packet_mmu_control_i (.core_clk,
    .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr(), .rxEvent, .txEvent, .txTake, .linkUpPin, .counterRollover,
    .statCounter, .eeDone, .rxHead, .rxPending, .txHead, .txPending,
    .complHead, .complPending, .txEmptyEvent(), .mergedEventIrq,
    .transmitterOn, .eeRequest, .eeStoreDir, .eeSelGpr);
  host_model host_model_i (.core_clk, .prdata, .pready, .psel, .penable,
    .pwrite, .paddr, .pwdata, .hung);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // a stuck bus or transfer counts against the run
  always @(posedge hung) begin
    failures++;
    wrapUp();
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    nTests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_model_i.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, logic [31:0] e);
    host_model_i.xfer(1'b0, a, 32'h0, rd);
    chk(nm, rd, e);
  endtask
  task automatic op(input logic [2:0] c);
    wr(8'h10, {24'h0, c, 5'h0});
  endtask
  // one-cycle mac pulses, then settle
  task automatic fire(input logic [7:0] r, t, input logic c, e);
    @(posedge core_clk);
    {rxEvent, txEvent, counterRollover, eeDone} <= {r, t, c, e};
    @(posedge core_clk);
    {rxEvent, txEvent, counterRollover, eeDone} <= '0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  initial begin
    {txTake, linkUpPin, counterRollover, eeDone, rxEvent, txEvent} = '0;
    statCounter = 16'h00a5;
    arst_n = 1'b0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    rdc("ctl busy", 8'h0c, 32'h3);
    fire(8'h0, 8'h0, 1'b0, 1'b1);
    host_model_i.poll();
    rdc("ctl reset", 8'h0c, 32'h1210);
    rdc("arr reset", 8'h18, 32'h80);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdc("row", rows[i].a, rows[i].e);
    end
    $display("rows done");
    op(3'h1);
    rdc("alloc", 8'h18, 32'h0);
    op(3'h1);
    rdc("alloc next", 8'h18, 32'h1);
    wr(8'h14, 32'h0);
    op(3'h5);
    op(3'h1);
    rdc("realloc", 8'h18, 32'h0);
    wr(8'h14, 32'h1);
    op(3'h6);
    wr(8'h20, 32'h1);
    chk("enqueue", {txPending, txHead}, 32'h41);
    wr(8'h0c, 32'h0820);
    fire(8'h0, 8'h81, 1'b0, 1'b0);
    chk("fatal", {mergedEventIrq, transmitterOn, complPending, complHead},
        32'h141);
    wr(8'h20, 32'h1);
    chk("fault ack", mergedEventIrq, 32'h0);
    wr(8'h20, 32'h0);
    op(3'h7);
    chk("tx reset", complPending, 32'h0);
    wr(8'h20, 32'h1);
    fire(8'h0, 8'hc1, 1'b0, 1'b0);
    chk("auto rel", {txPending, complPending}, 32'h0);
    $display("tx done");
    wr(8'h0c, 32'h0);
    fire(8'hc5, 8'h0, 1'b0, 1'b0);
    chk("crc drop", rxPending, 32'h0);
    wr(8'h0c, 32'h4000);
    fire(8'hc5, 8'h0, 1'b0, 1'b0);
    fire(8'h86, 8'h0, 1'b0, 1'b0);
    chk("crc keep", rxHead, 32'h5);
    op(3'h3);
    chk("remove", rxHead, 32'h6);
    op(3'h4);
    chk("rem rel", rxPending, 32'h0);
    fire(8'h87, 8'h0, 1'b0, 1'b0);
    op(3'h2);
    chk("mmu reset", rxPending, 32'h0);
    rdc("arr after", 8'h18, 32'h80);
    $display("rx done");
    wr(8'h0c, 32'h00c0);
    linkUpPin <= 1'b1;
    fire(8'h0, 8'h0, 1'b0, 1'b0);
    chk("link irq", mergedEventIrq, 32'h1);
    wr(8'h0c, 32'h0040);
    rdc("link ack", 8'h24, 32'h3);
    fire(8'h0, 8'h0, 1'b1, 1'b0);
    chk("roll irq", mergedEventIrq, 32'h1);
    rdc("counter", 8'h28, 32'h00a5);
    chk("roll ack", mergedEventIrq, 32'h0);
    $display("irq done");
    wr(8'h0c, 32'h0005);
    chk("store", {eeRequest, eeStoreDir, eeSelGpr}, 32'h7);
    wr(8'h14, 32'h3f);
    rdc("ee poll", 8'h0c, 32'h3);
    fire(8'h0, 8'h0, 1'b0, 1'b1);
    host_model_i.poll();
    rdc("ignored", 8'h14, 32'h0);
    wr(8'h0c, 32'h0002);
    chk("reload", {eeRequest, eeStoreDir, eeSelGpr}, 32'h4);
    host_model_i.poll();
    rdc("reload end", 8'h0c, 32'h1210);
    $display("eeprom done");
    wrapUp();
  end
endmodule // testbench
